// >>> common/cps_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cps_link_if;
    logic card_reset;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic [7:0] rdata;
    logic ready;
    logic personality;
    logic irq;
    logic [1:0] chan_reset_request;
    logic [1:0] buffer_free_flag;
    logic [15:0] card_size_data;
    logic [15:0] card_size_ext;
    logic [15:0] host_size;
    logic [1:0] host_size_we;
    logic poll_req;
    logic poll_ack;
    logic init_fault_flag;

    modport card (input card_reset, addr, wdata, we, re, chan_reset_request, host_size, host_size_we, poll_req,
                  output rdata, ready, personality, irq, buffer_free_flag, card_size_data, card_size_ext,
                  poll_ack, init_fault_flag);
    modport host (output card_reset, addr, wdata, we, re, chan_reset_request, host_size, host_size_we, poll_req,
                  input rdata, ready, personality, irq, buffer_free_flag, card_size_data, card_size_ext,
                  poll_ack, init_fault_flag);
endinterface // cps_link_if
`default_nettype wire

// >>> common/cps_pkg.sv
package cps_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SWITCH_WAIT_NS = 10_000;
    localparam int SWITCH_WAIT_CYC = (SWITCH_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FREE_TIMEOUT_S = 5;
    localparam int FREE_TIMEOUT_CYC = FREE_TIMEOUT_S * CLK_HZ;
    localparam int TMR_W = 26;
    localparam int WAIT_W = 8;
    localparam int NCHAN = 2;
    localparam int CH_DATA = 0;
    localparam int CH_EXT = 1;
    localparam logic [15:0] MIN_BUF_SIZE = 16'h0010;

    // Attribute space: tuple chain then option register
    localparam logic [7:0] TPL_ADDR_CODE = 8'h00;
    localparam logic [7:0] TPL_ADDR_LINK = 8'h01;
    localparam logic [7:0] TPL_ADDR_INDEX = 8'h02;
    localparam logic [7:0] TPL_ADDR_END = 8'h03;
    localparam int TPL_DEPTH = 4;
    localparam logic [7:0] TUPLE_CODE_BYTE_CFTABLE = 8'h1b;
    localparam logic [7:0] TPL_LINK_SHORT = 8'h01;
    localparam logic [7:0] TPL_INDEX_FLAGS = 8'hc0;
    localparam logic [7:0] TPL_CHAIN_TERMINATOR = 8'hff;
    localparam logic [7:0] CARD_CONFIG_OPTION_OFFSET = 8'h00;

    localparam int COR_SOFT_RESET_BIT = 7;
    localparam int COR_LEVEL_IRQ_BIT = 6;
    localparam int COR_INDEX_W = 6;
    localparam logic [7:0] COR_RESET = 8'h00;

    // Host controller register map
    localparam logic [3:0] HREG_CTRL = 4'h0;
    localparam logic [3:0] HREG_STATUS = 4'h1;
    localparam logic [3:0] HREG_MASK = 4'h2;
    localparam logic [3:0] HREG_SIZE_DATA = 4'h3;
    localparam logic [3:0] HREG_SIZE_EXT = 4'h4;
    localparam logic [3:0] HREG_INFO = 4'h5;
    localparam int CTRL_CFG = 0;
    localparam int CTRL_RS_DATA = 1;
    localparam int CTRL_RS_EXT = 2;
    localparam int CTRL_POLL = 3;
    localparam int CTRL_CARD_RESET = 4;
    localparam int ST_CFG_DONE = 0;
    localparam int ST_TUPLE_BAD = 1;
    localparam int ST_FREE_TO = 2;
    localparam int ST_SMALL_OFFER = 4;
    localparam int ST_READY_TO = 6;
    localparam int ST_CARD_FAULT = 7;
    localparam int INFO_READY = 0;
    localparam int INFO_PERSONA = 1;
    localparam int INFO_FREE = 2;
    localparam int INFO_POLL_ACK = 4;
    localparam int INFO_BUSY = 5;

    typedef enum logic [2:0] {
        CPS_H_IDLE, CPS_H_RD_INDEX, CPS_H_RD_END, CPS_H_CHECK, CPS_H_WR_CFG
    } cps_host_state_t;
endpackage

// >>> rtl/cps_card.sv
`timescale 1ns/1ps
`default_nettype none
module cps_card #(
    parameter logic [5:0] CFG_INDEX = 6'h01,
    parameter logic [15:0] BUF_SIZE_DATA = 16'h0100,
    parameter logic [15:0] BUF_SIZE_EXT = 16'h0100,
    parameter int FREE_DELAY_CYC = 16
) (
    input wire logic clk,
    input wire logic srst,
    cps_link_if.card lnk,
    input wire logic irq_event,
    input wire logic irq_clear,
    output logic personality_active,
    output logic [15:0] buf_size_data,
    output logic [15:0] buf_size_ext,
    output logic init_fault
);
    typedef struct packed {
        logic [7:0] cor;
        logic armed;
        logic [cps_pkg::WAIT_W-1:0] wait_cnt;
        logic persona;
        logic [cps_pkg::NCHAN-1:0] chan_busy;
        logic [cps_pkg::NCHAN-1:0][15:0] chan_cnt;
        logic [cps_pkg::NCHAN-1:0] free;
        logic [cps_pkg::NCHAN-1:0][15:0] size;
        logic fault;
        logic irq;
        logic [7:0] rdata;
        logic poll_ack;
        logic ready;
    } cps_card_state_t;

    cps_card_state_t s_q, s_d;
    logic rst;
    logic [7:0] tpl_rom [cps_pkg::TPL_DEPTH];
    logic [15:0] own_size [cps_pkg::NCHAN];

    assign rst = srst | lnk.card_reset;
    assign own_size[cps_pkg::CH_DATA] = BUF_SIZE_DATA;
    assign own_size[cps_pkg::CH_EXT] = BUF_SIZE_EXT;
    assign tpl_rom[0] = cps_pkg::TUPLE_CODE_BYTE_CFTABLE;
    assign tpl_rom[1] = cps_pkg::TPL_LINK_SHORT;
    assign tpl_rom[2] = cps_pkg::TPL_INDEX_FLAGS | {2'h0, CFG_INDEX};
    assign tpl_rom[3] = cps_pkg::TPL_CHAIN_TERMINATOR;

    always_comb begin
        s_d = s_q;
        s_d.ready = 1'b1;
        s_d.rdata = 8'h00;
        s_d.poll_ack = 1'b0;
        if (lnk.re) begin
            if (s_q.persona) begin
                s_d.rdata = 8'h00;
            end else if (lnk.addr == cps_pkg::CARD_CONFIG_OPTION_OFFSET + 8'h80) begin
                s_d.rdata = s_q.cor;
            end else if (lnk.addr < 8'(cps_pkg::TPL_DEPTH)) begin
                s_d.rdata = tpl_rom[lnk.addr[1:0]];
            end else begin
                s_d.rdata = cps_pkg::TPL_CHAIN_TERMINATOR;
            end
        end
        if (lnk.we && !s_q.persona && lnk.addr == cps_pkg::CARD_CONFIG_OPTION_OFFSET + 8'h80) begin
            s_d.cor = lnk.wdata;
            if (lnk.wdata[cps_pkg::COR_SOFT_RESET_BIT]) begin
                // Soft reset keeps only the new option value and ready flag, then irq, poll_ack, wait_cnt and a switch wait ending now still update
                s_d = '0;
                s_d.ready = 1'b1;
                s_d.cor = lnk.wdata;
            end else if (lnk.wdata[cps_pkg::COR_INDEX_W-1:0] == CFG_INDEX) begin
                s_d.armed = 1'b1;
                s_d.wait_cnt = '0;
            end else begin
                s_d.armed = 1'b0;
            end
        end
        if (s_q.armed) begin
            if (s_q.wait_cnt == cps_pkg::WAIT_W'(cps_pkg::SWITCH_WAIT_CYC - 1)) begin
                s_d.armed = 1'b0;
                s_d.persona = 1'b1;
            end else begin
                s_d.wait_cnt = s_q.wait_cnt + 1'b1;
            end
        end
        for (int c = 0; c < cps_pkg::NCHAN; c++) begin
            if (lnk.chan_reset_request[c] && s_q.persona) begin
                s_d.free[c] = 1'b0;
                s_d.chan_busy[c] = 1'b1;
                s_d.chan_cnt[c] = '0;
            end else if (s_q.chan_busy[c]) begin
                // Free flag comes far inside the 5 s the host allows
                if (s_q.chan_cnt[c] == 16'(FREE_DELAY_CYC - 1)) begin
                    s_d.chan_busy[c] = 1'b0;
                    s_d.free[c] = 1'b1;
                end else begin
                    s_d.chan_cnt[c] = s_q.chan_cnt[c] + 16'h0001;
                end
            end
            if (lnk.host_size_we[c] && s_q.persona) begin
                if (lnk.host_size < cps_pkg::MIN_BUF_SIZE || lnk.host_size > own_size[c]) begin
                    s_d.fault = 1'b1;
                end else begin
                    s_d.size[c] = lnk.host_size;
                end
            end
        end
        if (lnk.poll_req && !s_q.fault) begin
            s_d.poll_ack = 1'b1;
        end
        if (s_q.cor[cps_pkg::COR_LEVEL_IRQ_BIT]) begin
            // Level mode holds the request until the card side clears it
            if (irq_event) begin
                s_d.irq = 1'b1;
            end else if (irq_clear) begin
                s_d.irq = 1'b0;
            end
        end else begin
            s_d.irq = irq_event;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign lnk.rdata = s_q.rdata;
    assign lnk.ready = s_q.ready;
    assign lnk.personality = s_q.persona;
    assign lnk.irq = s_q.irq;
    assign lnk.buffer_free_flag = s_q.free;
    assign lnk.card_size_data = BUF_SIZE_DATA;
    assign lnk.card_size_ext = BUF_SIZE_EXT;
    assign lnk.poll_ack = s_q.poll_ack;
    assign lnk.init_fault_flag = s_q.fault;
    assign personality_active = s_q.persona;
    assign buf_size_data = s_q.size[cps_pkg::CH_DATA];
    assign buf_size_ext = s_q.size[cps_pkg::CH_EXT];
    assign init_fault = s_q.fault;
endmodule // cps_card
`default_nettype wire

// >>> rtl/cps_host.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module cps_host #(
    parameter int FREE_TIMEOUT_CYC = cps_pkg::FREE_TIMEOUT_CYC,
    parameter int READY_TIMEOUT_CYC = cps_pkg::FREE_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    cps_link_if.host lnk,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq
);
    typedef struct packed {
        cps_pkg::cps_host_state_t st;
        logic [7:0] index_byte;
        logic [7:0] status;
        logic [7:0] mask;
        logic [cps_pkg::NCHAN-1:0][15:0] size;
        logic [cps_pkg::NCHAN-1:0] waiting;
        logic [cps_pkg::NCHAN-1:0][cps_pkg::TMR_W-1:0] tmr;
        logic [cps_pkg::TMR_W-1:0] rdy_tmr;
        logic rdy_seen;
        logic poll_sent;
        logic poll_ack;
        logic [7:0] rdata;
        logic [7:0] laddr;
        logic [7:0] lwdata;
        logic lwe;
        logic lre;
        logic [cps_pkg::NCHAN-1:0] rs;
        logic [cps_pkg::NCHAN-1:0] size_we;
        logic [15:0] size_out;
        logic poll_req;
        logic card_reset;
    } cps_host_state_s_t;

    cps_host_state_s_t s_q, s_d;
    logic [7:0] ev;
    logic [15:0] offer [cps_pkg::NCHAN];

    assign offer[cps_pkg::CH_DATA] = lnk.card_size_data;
    assign offer[cps_pkg::CH_EXT] = lnk.card_size_ext;

    always_comb begin
        s_d = s_q;
        ev = 8'h00;
        s_d.lwe = 1'b0;
        s_d.lre = 1'b0;
        s_d.rs = '0;
        s_d.size_we = '0;
        s_d.poll_req = 1'b0;
        s_d.card_reset = 1'b0;
        s_d.rdata = 8'h00;
        case (s_q.st)
            cps_pkg::CPS_H_IDLE: begin
                if (wr && addr == cps_pkg::HREG_CTRL && wdata[cps_pkg::CTRL_CFG]) begin
                    s_d.laddr = cps_pkg::TPL_ADDR_INDEX;
                    s_d.lre = 1'b1;
                    s_d.st = cps_pkg::CPS_H_RD_INDEX;
                end
            end
            cps_pkg::CPS_H_RD_INDEX: begin
                s_d.laddr = cps_pkg::TPL_ADDR_END;
                s_d.lre = 1'b1;
                s_d.st = cps_pkg::CPS_H_RD_END;
            end
            cps_pkg::CPS_H_RD_END: begin
                s_d.index_byte = lnk.rdata;
                s_d.st = cps_pkg::CPS_H_CHECK;
            end
            cps_pkg::CPS_H_CHECK: begin
                if (lnk.rdata != cps_pkg::TPL_CHAIN_TERMINATOR) begin
                    ev[cps_pkg::ST_TUPLE_BAD] = 1'b1;
                    s_d.st = cps_pkg::CPS_H_IDLE;
                end else begin
                    s_d.laddr = cps_pkg::CARD_CONFIG_OPTION_OFFSET + 8'h80;
                    s_d.lwdata = 8'h00;
                    s_d.lwdata[cps_pkg::COR_SOFT_RESET_BIT] = 1'b0;
                    s_d.lwdata[cps_pkg::COR_LEVEL_IRQ_BIT] = 1'b1;
                    s_d.lwdata[cps_pkg::COR_INDEX_W-1:0] = s_q.index_byte[cps_pkg::COR_INDEX_W-1:0];
                    s_d.lwe = 1'b1;
                    s_d.st = cps_pkg::CPS_H_WR_CFG;
                end
            end
            cps_pkg::CPS_H_WR_CFG: begin
                ev[cps_pkg::ST_CFG_DONE] = 1'b1;
                s_d.st = cps_pkg::CPS_H_IDLE;
            end
            default: begin
                s_d.st = cps_pkg::CPS_H_IDLE;
            end
        endcase
        if (wr && addr == cps_pkg::HREG_CTRL) begin
            s_d.poll_req = wdata[cps_pkg::CTRL_POLL];
            if (wdata[cps_pkg::CTRL_CARD_RESET]) begin
                s_d.card_reset = 1'b1;
                s_d.rdy_seen = 1'b0;
                s_d.rdy_tmr = '0;
            end
        end
        // Card answers an edge after it sees the request, so look one edge later
        s_d.poll_sent = s_q.poll_req;
        if (s_q.poll_sent) begin
            s_d.poll_ack = lnk.poll_ack;
        end
        if (lnk.init_fault_flag) begin
            ev[cps_pkg::ST_CARD_FAULT] = 1'b1;
        end
        if (!s_q.rdy_seen) begin
            if (lnk.ready) begin
                s_d.rdy_seen = 1'b1;
            end else if (s_q.rdy_tmr == cps_pkg::TMR_W'(READY_TIMEOUT_CYC - 1)) begin
                ev[cps_pkg::ST_READY_TO] = 1'b1;
                s_d.rdy_seen = 1'b1;
            end else begin
                s_d.rdy_tmr = s_q.rdy_tmr + 1'b1;
            end
        end
        for (int c = 0; c < cps_pkg::NCHAN; c++) begin
            if (wr && addr == cps_pkg::HREG_CTRL && wdata[cps_pkg::CTRL_RS_DATA + c]) begin
                s_d.rs[c] = 1'b1;
                s_d.waiting[c] = 1'b1;
                s_d.tmr[c] = '0;
            end else if (s_q.waiting[c]) begin
                if (lnk.buffer_free_flag[c] && !s_q.rs[c]) begin
                    s_d.waiting[c] = 1'b0;
                end else if (s_q.tmr[c] == cps_pkg::TMR_W'(FREE_TIMEOUT_CYC - 1)) begin
                    // Wrong index also ends here, the card never answers
                    ev[cps_pkg::ST_FREE_TO + c] = 1'b1;
                    s_d.waiting[c] = 1'b0;
                end else begin
                    s_d.tmr[c] = s_q.tmr[c] + 1'b1;
                end
            end
            if (wr && addr == cps_pkg::HREG_SIZE_DATA + 4'(c)) begin
                if (offer[c] < cps_pkg::MIN_BUF_SIZE) begin
                    ev[cps_pkg::ST_SMALL_OFFER + c] = 1'b1;
                end
                s_d.size[c] = {8'h00, wdata};
                s_d.size_out = {8'h00, wdata};
                s_d.size_we[c] = 1'b1;
            end
        end
        if (rd) begin
            case (addr)
                cps_pkg::HREG_STATUS: s_d.rdata = s_q.status;
                cps_pkg::HREG_MASK: s_d.rdata = s_q.mask;
                cps_pkg::HREG_SIZE_DATA: s_d.rdata = s_q.size[cps_pkg::CH_DATA][7:0];
                cps_pkg::HREG_SIZE_EXT: s_d.rdata = s_q.size[cps_pkg::CH_EXT][7:0];
                cps_pkg::HREG_INFO: begin
                    s_d.rdata[cps_pkg::INFO_READY] = lnk.ready;
                    s_d.rdata[cps_pkg::INFO_PERSONA] = lnk.personality;
                    s_d.rdata[cps_pkg::INFO_FREE +: cps_pkg::NCHAN] = lnk.buffer_free_flag;
                    s_d.rdata[cps_pkg::INFO_POLL_ACK] = s_q.poll_ack;
                    s_d.rdata[cps_pkg::INFO_BUSY] = s_q.st != cps_pkg::CPS_H_IDLE;
                end
                default: s_d.rdata = 8'h00;
            endcase
        end
        if (wr && addr == cps_pkg::HREG_MASK) begin
            s_d.mask = wdata;
        end
        // Set beats clear so no event slips through a write of one
        if (wr && addr == cps_pkg::HREG_STATUS) begin
            s_d.status = (s_q.status & ~wdata) | ev;
        end else begin
            s_d.status = s_q.status | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign irq = |(s_q.status & s_q.mask);
    assign lnk.card_reset = s_q.card_reset;
    assign lnk.addr = s_q.laddr;
    assign lnk.wdata = s_q.lwdata;
    assign lnk.we = s_q.lwe;
    assign lnk.re = s_q.lre;
    assign lnk.chan_reset_request = s_q.rs;
    assign lnk.host_size = s_q.size_out;
    assign lnk.host_size_we = s_q.size_we;
    assign lnk.poll_req = s_q.poll_req;
endmodule // cps_host
`default_nettype wire

// >>> verif/cps_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cps_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic card_reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic re,
    input wire logic [7:0] rdata,
    input wire logic personality,
    input wire logic [1:0] chan_reset_request,
    input wire logic [1:0] buffer_free_flag,
    input wire logic [15:0] card_size_data,
    input wire logic [15:0] card_size_ext,
    input wire logic [15:0] host_size,
    input wire logic [1:0] host_size_we,
    input wire logic poll_req,
    input wire logic poll_ack,
    input wire logic init_fault_flag
);
    logic [7:0] wait_q;
    logic [7:0] wait_d;
    // Edges since the last option write, saturating so old writes stay old
    always_comb begin
        wait_d = (wait_q == 8'hff) ? wait_q : wait_q + 8'h01;
        if (we && addr == 8'h80) begin
            wait_d = 8'h00;
        end
    end
    always_ff @(posedge clk) begin
        wait_q <= srst ? 8'hff : wait_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_cfg_write;
        we && addr == 8'h80 && !wdata[7];
    endsequence
    sequence s_size_bad;
        host_size_we[0] && personality && (host_size < 16'h0010 || host_size > card_size_data);
    endsequence
    property p_free(logic req, logic flg);
        req && personality && !card_reset |-> ##[1:40] flg;
    endproperty
    a_switch_min: assert property ($rose(personality) |-> wait_q >= 8'h64)
        else $error("personality switched too early");
    a_switch_bound: assert property (s_cfg_write |-> ##[1:110] personality)
        else $error("personality never switched");
    a_cfg_value: assert property (we && addr == 8'h80 |-> !wdata[7] && wdata[6])
        else $error("bad option register value");
    a_tuple_end: assert property (re && addr == 8'h03 && !personality && !card_reset |=> rdata == 8'hff)
        else $error("chain end code wrong");
    a_free_data: assert property (p_free(chan_reset_request[0], buffer_free_flag[0]))
        else $error("data free flag late");
    a_free_ext: assert property (p_free(chan_reset_request[1], buffer_free_flag[1]))
        else $error("extended free flag late");
    a_size_data: assert property (s_size_bad |-> ##[1:3] init_fault_flag)
        else $error("bad data size not faulted");
    a_size_ext: assert property (host_size_we[1] && personality && (host_size < 16'h0010 || host_size > card_size_ext)
        |-> ##[1:3] init_fault_flag)
        else $error("bad extended size not faulted");
    a_fault_sticky: assert property (init_fault_flag && !card_reset |=> init_fault_flag)
        else $error("fault flag dropped");
    a_poll_silent: assert property (init_fault_flag |-> !poll_ack)
        else $error("poll answered in fault");
    a_poll_answer: assert property (poll_req && !init_fault_flag && !card_reset |=> poll_ack)
        else $error("poll not answered");
endmodule // cps_monitor
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk;
    logic srst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic irq;
    logic irq_event;
    logic irq_clear;
    logic personality_active;
    logic [15:0] buf_size_data;
    logic [15:0] buf_size_ext;
    logic init_fault;
    logic [15:0] got;
    logic [7:0] sz;
    int err_total;
    int tests_run;
    cps_link_if lnk_if ();
    cps_card #(.CFG_INDEX(6'h2a)) cps_card_i (.clk(clk), .srst(srst), .lnk(lnk_if.card), .irq_event(irq_event),
        .irq_clear(irq_clear), .personality_active(personality_active), .buf_size_data(buf_size_data),
        .buf_size_ext(buf_size_ext), .init_fault(init_fault));
    // Short timeouts keep the failure paths inside a short run
    cps_host #(.FREE_TIMEOUT_CYC(200), .READY_TIMEOUT_CYC(200)) cps_host_i (.clk(clk), .srst(srst),
        .lnk(lnk_if.host), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    cps_monitor cps_monitor_i (.clk(clk), .srst(srst), .card_reset(lnk_if.card_reset), .addr(lnk_if.addr),
        .wdata(lnk_if.wdata), .we(lnk_if.we), .re(lnk_if.re), .rdata(lnk_if.rdata),
        .personality(lnk_if.personality), .chan_reset_request(lnk_if.chan_reset_request),
        .buffer_free_flag(lnk_if.buffer_free_flag), .card_size_data(lnk_if.card_size_data),
        .card_size_ext(lnk_if.card_size_ext),
        .host_size(lnk_if.host_size), .host_size_we(lnk_if.host_size_we), .poll_req(lnk_if.poll_req),
        .poll_ack(lnk_if.poll_ack), .init_fault_flag(lnk_if.init_fault_flag));
    function automatic logic size_ok(input logic [7:0] s);
        return s >= 8'h10 && {8'h00, s} <= 16'h0100;
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 got = {8'h00, rdata};
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic summarize();
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial begin
        #500_000;
        err_total++;
        summarize();
    end
    initial begin
        srst = 1'h1;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'h0;
        rd = 1'h0;
        irq_event = 1'h0;
        irq_clear = 1'h0;
        err_total = 0;
        tests_run = 0;
        void'($urandom(51691));
        repeat (4) @(posedge clk);
        srst <= 1'h0;
        cyc(3);
        rd_reg(cps_pkg::HREG_INFO);
        chk(got & 16'h0001, 16'h0001, "ready");
        // Option register still clear before the switch, so events leave as pulses
        @(posedge clk) irq_event <= 1'h1;
        @(posedge clk) irq_event <= 1'h0;
        #1 chk({15'h0, lnk_if.irq}, 16'h0001, "pulse irq");
        cyc(1);
        chk({15'h0, lnk_if.irq}, 16'h0000, "pulse irq end");
        wr_reg(cps_pkg::HREG_CTRL, 8'h01);
        cyc(8);
        rd_reg(cps_pkg::HREG_STATUS);
        chk(got, 16'h0001, "config status");
        chk({15'h0, personality_active}, 16'h0000, "early switch");
        cyc(110);
        chk({15'h0, personality_active}, 16'h0001, "switch");
        rd_reg(cps_pkg::HREG_INFO);
        chk(got & 16'h0003, 16'h0003, "info persona");
        // Masked status must not reach the line
        wr_reg(cps_pkg::HREG_MASK, 8'h00);
        cyc(1);
        chk({15'h0, irq}, 16'h0000, "masked irq");
        wr_reg(cps_pkg::HREG_MASK, 8'h01);
        cyc(1);
        chk({15'h0, irq}, 16'h0001, "irq");
        wr_reg(cps_pkg::HREG_STATUS, 8'h01);
        cyc(1);
        chk({15'h0, irq}, 16'h0000, "irq cleared");
        @(posedge clk) irq_event <= 1'h1;
        @(posedge clk) irq_event <= 1'h0;
        cyc(5);
        chk({15'h0, lnk_if.irq}, 16'h0001, "level irq held");
        @(posedge clk) irq_clear <= 1'h1;
        @(posedge clk) irq_clear <= 1'h0;
        cyc(3);
        chk({15'h0, lnk_if.irq}, 16'h0000, "level irq cleared");
        wr_reg(cps_pkg::HREG_CTRL, 8'h06);
        cyc(30);
        rd_reg(cps_pkg::HREG_INFO);
        chk(got & 16'h000c, 16'h000c, "free flags");
        wr_reg(cps_pkg::HREG_CTRL, 8'h08);
        cyc(3);
        rd_reg(cps_pkg::HREG_INFO);
        chk(got & 16'h0010, 16'h0010, "poll ack");
        for (int i = 0; i < 8; i++) begin
            sz = (i == 0) ? 8'h10 : (i == 1) ? 8'hff : 8'h10 + 8'($urandom % 240);
            wr_reg(i[0] ? cps_pkg::HREG_SIZE_EXT : cps_pkg::HREG_SIZE_DATA, sz);
            cyc(3);
            chk(i[0] ? buf_size_ext : buf_size_data, {8'h00, sz}, "adopt size");
            chk({15'h0, init_fault}, {15'h0, ~size_ok(sz)}, "size fault");
        end
        rd_reg(cps_pkg::HREG_STATUS);
        chk(got & 16'h0030, 16'h0000, "offer flags");
        wr_reg(cps_pkg::HREG_SIZE_EXT, 8'h0f);
        cyc(3);
        chk({15'h0, init_fault}, {15'h0, ~size_ok(8'h0f)}, "small size");
        rd_reg(cps_pkg::HREG_STATUS);
        chk(got & 16'h0080, 16'h0080, "fault status");
        wr_reg(cps_pkg::HREG_CTRL, 8'h08);
        cyc(3);
        rd_reg(cps_pkg::HREG_INFO);
        chk(got & 16'h0010, 16'h0000, "poll silent");
        wr_reg(cps_pkg::HREG_CTRL, 8'h10);
        cyc(5);
        chk({14'h0, init_fault, personality_active}, 16'h0000, "card reset");
        wr_reg(cps_pkg::HREG_STATUS, 8'hff);
        // Without the personality the card leaves the request unanswered
        wr_reg(cps_pkg::HREG_CTRL, 8'h02);
        cyc(250);
        rd_reg(cps_pkg::HREG_STATUS);
        chk(got & 16'h0004, 16'h0004, "free timeout");
        summarize();
    end
endmodule // tb
`default_nettype wire
